// File: src/mcp_pkg.sv
// constants, register map and state codes of the main clock prescaler control block
// Summary of operation
// - byte, halfword and word accesses all accepted
// - byte lanes of every register written separately
// - clock failure sets backup source select bit
// - select bit picks generic or backup clock
// - detector enable bit turns detector on
// - idle code picks which domains stop
// - idle code applies on wait for interrupt
// - processor clock divided by two to code
// - bus a clock divided by two to code
// - bus b clock divided by two to code
// - bus c clock divided by two to code
// - sleep config register resets to zero
// - protection input blocks writes to control, sleep, divider and gate registers
// - write one clears flag, sets or clears enable
// - irq high while enabled flag set
// - standby holds dividers and hardware events until the clocked wake interrupt
package mcp_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] MCP_IDX_CTRL      = 6'h00;
  localparam logic [5:0] MCP_IDX_SLEEP     = 6'h01;
  localparam logic [5:0] MCP_IDX_CPU_DIV   = 6'h08;
  localparam logic [5:0] MCP_IDX_BUS_A_DIV = 6'h09;
  localparam logic [5:0] MCP_IDX_BUS_B_DIV = 6'h0a;
  localparam logic [5:0] MCP_IDX_BUS_C_DIV = 6'h0b;
  localparam logic [5:0] MCP_IDX_SYS_GATES = 6'h14;
  localparam logic [5:0] MCP_IDX_A_GATES   = 6'h18;
  localparam logic [5:0] MCP_IDX_B_GATES   = 6'h1c;
  localparam logic [5:0] MCP_IDX_C_GATES   = 6'h20;
  localparam logic [5:0] MCP_IDX_IRQ_ENCLR = 6'h34;
  localparam logic [5:0] MCP_IDX_IRQ_ENSET = 6'h35;
  localparam logic [5:0] MCP_IDX_IRQ_FLAGS = 6'h36;
  localparam logic [5:0] MCP_IDX_RST_SRC   = 6'h38;

  // field positions
  localparam int MCP_BIT_FDET_EN    = 2;
  localparam int MCP_BIT_BACKUP_SEL = 4;
  localparam int MCP_BIT_CLK_READY  = 0;
  localparam int MCP_BIT_CLK_FAIL   = 1;

  // reset values
  localparam logic [7:0]  MCP_RST_CTRL    = 8'h00;
  localparam logic [1:0]  MCP_RST_IDLE    = 2'h0;
  localparam logic [2:0]  MCP_RST_DIV     = 3'h0;
  localparam logic [31:0] MCP_RST_SYS_GATES = 32'h0000007f;
  localparam logic [31:0] MCP_RST_A_GATES   = 32'h0000007f;
  localparam logic [31:0] MCP_RST_B_GATES   = 32'h0000007f;
  localparam logic [31:0] MCP_RST_C_GATES   = 32'h000fffff;

  // implemented bits of each gate register and of the reset source
  localparam logic [31:0] MCP_MASK_SYS_GATES = 32'h0000001f;
  localparam logic [31:0] MCP_MASK_A_GATES   = 32'h0000007f;
  localparam logic [31:0] MCP_MASK_B_GATES   = 32'h0000000f;
  localparam logic [31:0] MCP_MASK_C_GATES   = 32'h000fffff;
  localparam logic [7:0]  MCP_MASK_RST_SRC   = 8'h77;

  // idle configuration codes
  localparam logic [1:0] MCP_IDLE_CPU = 2'h0;
  localparam logic [1:0] MCP_IDLE_SYS = 2'h1;
  localparam logic [1:0] MCP_IDLE_BUS = 2'h2;

  // divider domains
  localparam int MCP_DOMAINS = 4;
  localparam int MCP_CNT_W   = 7;

  typedef enum logic [2:0] {
    MCP_ACTIVE  = 3'h1,
    MCP_IDLE    = 3'h2,
    MCP_STANDBY = 3'h4
  } mcp_state_type;

endpackage : mcp_pkg

// File: src/mcp_clock_control.sv
// main clock prescaler control: register file, sleep levels, dividers and interrupts
module mcp_clock_control (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_wdata,
  output logic      [31:0] wb_rdata,
  output logic             wb_ack,
  input  wire logic        write_protect,
  input  wire logic        clock_failure_detect,
  input  wire logic        clock_ready_event,
  input  wire logic        wait_for_interrupt_instruction,
  input  wire logic        sleep_deep,
  input  wire logic        wake_interrupt,
  input  wire logic [7:0]  reset_cause,
  output logic             main_clock_from_backup,
  output logic             failure_detector_on,
  output logic             cpu_clock_enable,
  output logic             system_bus_clock_enable,
  output logic             bus_a_clock_enable,
  output logic             bus_b_clock_enable,
  output logic             bus_c_clock_enable,
  output logic      [31:0] system_bus_gates,
  output logic      [31:0] bus_a_gates,
  output logic      [31:0] bus_b_gates,
  output logic      [31:0] bus_c_gates,
  output logic             irq
);

  // whole state of the block in one record
  typedef struct packed {
    mcp_pkg::mcp_state_type                        state;
    logic                                          failure_detector_enable;
    logic                                          backup_source_select;
    logic [1:0]                                    idle_cfg;
    logic [mcp_pkg::MCP_DOMAINS-1:0][2:0]          div_code;
    logic [mcp_pkg::MCP_DOMAINS-1:0][2:0]          div_active;
    logic [mcp_pkg::MCP_DOMAINS-1:0][mcp_pkg::MCP_CNT_W-1:0] div_cnt;
    logic [mcp_pkg::MCP_DOMAINS-1:0]               div_tick;
    logic                                          sys_tick;
    logic [3:0][31:0]                              gates;
    logic [1:0]                                    irq_en;
    logic [1:0]                                    irq_flag;
    logic                                          fail_seen;
    logic [7:0]                                    rst_src;
    logic                                          rst_src_taken;
    logic                                          ack;
    logic [31:0]                                   rdata;
    logic                                          irq;
  } mcp_regs_type;

  // reset image; counters start at zero so code 0 ticks on the first edge
  localparam mcp_regs_type MCP_RESET_STATE = '{
    state:                   mcp_pkg::MCP_ACTIVE,
    failure_detector_enable: mcp_pkg::MCP_RST_CTRL[mcp_pkg::MCP_BIT_FDET_EN],
    backup_source_select:    mcp_pkg::MCP_RST_CTRL[mcp_pkg::MCP_BIT_BACKUP_SEL],
    idle_cfg:                mcp_pkg::MCP_RST_IDLE,
    div_code:                {mcp_pkg::MCP_DOMAINS{mcp_pkg::MCP_RST_DIV}},
    div_active:              {mcp_pkg::MCP_DOMAINS{mcp_pkg::MCP_RST_DIV}},
    div_cnt:                 '0,
    div_tick:                '0,
    sys_tick:                1'b0,
    gates:                   {mcp_pkg::MCP_RST_C_GATES, mcp_pkg::MCP_RST_B_GATES,
                              mcp_pkg::MCP_RST_A_GATES, mcp_pkg::MCP_RST_SYS_GATES},
    irq_en:                  2'h0,
    irq_flag:                2'h0,
    fail_seen:               1'b0,
    rst_src:                 8'h00,
    rst_src_taken:           1'b0,
    ack:                     1'b0,
    rdata:                   32'h00000000,
    irq:                     1'b0
  };

  mcp_regs_type r;
  mcp_regs_type n;

  logic [5:0]  idx;
  logic        wr_hit;
  logic        wr_ok;
  logic        rd_start;
  logic [31:0] merged;
  logic [31:0] rd_val;
  logic        fail_event;
  logic        stop_cpu;
  logic        stop_sys;
  logic        stop_bus;
  logic        frozen;

  // merge write data into an old value by byte lane
  function automatic logic [31:0] mcp_merge(input logic [31:0] old_val,
                                           input logic [31:0] wdat,
                                           input logic [3:0]  sel);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    return res;
  endfunction : mcp_merge

  // last counter value of one divider period for a code
  function automatic logic [mcp_pkg::MCP_CNT_W-1:0] mcp_period_last(input logic [2:0] code);
    logic [7:0] full;
    full = (8'h01 << code) - 8'h01;
    return full[mcp_pkg::MCP_CNT_W-1:0];
  endfunction : mcp_period_last

  // registers guarded by the protection input
  function automatic logic mcp_protected(input logic [5:0] i);
    return (i == mcp_pkg::MCP_IDX_CTRL) || (i == mcp_pkg::MCP_IDX_SLEEP) ||
           (i == mcp_pkg::MCP_IDX_CPU_DIV) || (i == mcp_pkg::MCP_IDX_BUS_A_DIV) ||
           (i == mcp_pkg::MCP_IDX_BUS_B_DIV) || (i == mcp_pkg::MCP_IDX_BUS_C_DIV) ||
           (i == mcp_pkg::MCP_IDX_SYS_GATES) || (i == mcp_pkg::MCP_IDX_A_GATES) ||
           (i == mcp_pkg::MCP_IDX_B_GATES) || (i == mcp_pkg::MCP_IDX_C_GATES);
  endfunction : mcp_protected

  // read mux over the register map; unmapped words read zero
  always_comb begin
    rd_val = 32'h00000000;
    case (idx)
      mcp_pkg::MCP_IDX_CTRL: begin
        rd_val[mcp_pkg::MCP_BIT_FDET_EN]    = r.failure_detector_enable;
        rd_val[mcp_pkg::MCP_BIT_BACKUP_SEL] = r.backup_source_select;
      end
      mcp_pkg::MCP_IDX_SLEEP: begin
        rd_val[1:0] = r.idle_cfg;
      end
      mcp_pkg::MCP_IDX_CPU_DIV: begin
        rd_val[2:0] = r.div_code[0];
      end
      mcp_pkg::MCP_IDX_BUS_A_DIV: begin
        rd_val[2:0] = r.div_code[1];
      end
      mcp_pkg::MCP_IDX_BUS_B_DIV: begin
        rd_val[2:0] = r.div_code[2];
      end
      mcp_pkg::MCP_IDX_BUS_C_DIV: begin
        rd_val[2:0] = r.div_code[3];
      end
      mcp_pkg::MCP_IDX_SYS_GATES: begin
        rd_val = r.gates[0];
      end
      mcp_pkg::MCP_IDX_A_GATES: begin
        rd_val = r.gates[1];
      end
      mcp_pkg::MCP_IDX_B_GATES: begin
        rd_val = r.gates[2];
      end
      mcp_pkg::MCP_IDX_C_GATES: begin
        rd_val = r.gates[3];
      end
      mcp_pkg::MCP_IDX_IRQ_ENCLR: begin
        rd_val[1:0] = r.irq_en;
      end
      mcp_pkg::MCP_IDX_IRQ_ENSET: begin
        rd_val[1:0] = r.irq_en;
      end
      mcp_pkg::MCP_IDX_IRQ_FLAGS: begin
        rd_val[1:0] = r.irq_flag;
      end
      mcp_pkg::MCP_IDX_RST_SRC: begin
        rd_val[7:0] = r.rst_src;
      end
      default: begin
        rd_val = 32'h00000000;
      end
    endcase
  end

  // next-state logic for the whole block
  always_comb begin
    n          = r;
    idx        = wb_adr[7:2];
    rd_start   = wb_cyc & wb_stb & ~r.ack;
    // a write lands at the edge where the master sees ack
    wr_hit     = r.ack & wb_cyc & wb_stb & wb_we;
    wr_ok      = wr_hit & ~(write_protect & mcp_protected(idx));
    frozen     = (r.state == mcp_pkg::MCP_STANDBY);
    fail_event = r.failure_detector_enable & clock_failure_detect & ~r.fail_seen;
    merged     = 32'h00000000;

    // bus handshake: ack one cycle after the request, dropped the next cycle
    n.ack = rd_start;
    if (rd_start) begin
      n.rdata = rd_val;
    end

    // reset source is caught once, on the first edge after release
    if (!r.rst_src_taken) begin
      n.rst_src       = reset_cause & mcp_pkg::MCP_MASK_RST_SRC;
      n.rst_src_taken = 1'b1;
    end

    // register writes, byte lanes merged separately
    if (wr_ok) begin
      case (idx)
        mcp_pkg::MCP_IDX_CTRL: begin
          merged = mcp_merge({24'h000000,
                              3'h0, r.backup_source_select, 1'b0,
                              r.failure_detector_enable, 2'h0},
                             wb_wdata, wb_sel);
          n.failure_detector_enable = merged[mcp_pkg::MCP_BIT_FDET_EN];
          n.backup_source_select    = merged[mcp_pkg::MCP_BIT_BACKUP_SEL];
        end
        mcp_pkg::MCP_IDX_SLEEP: begin
          merged     = mcp_merge({30'h00000000, r.idle_cfg}, wb_wdata, wb_sel);
          n.idle_cfg = merged[1:0];
        end
        mcp_pkg::MCP_IDX_CPU_DIV, mcp_pkg::MCP_IDX_BUS_A_DIV,
        mcp_pkg::MCP_IDX_BUS_B_DIV, mcp_pkg::MCP_IDX_BUS_C_DIV: begin
          // only lane 0 matters; wider access here is not expected
          merged = mcp_merge({29'h00000000, r.div_code[idx[1:0]]}, wb_wdata, wb_sel);
          n.div_code[idx[1:0]] = merged[2:0];
        end
        mcp_pkg::MCP_IDX_SYS_GATES: begin
          n.gates[0] = mcp_merge(r.gates[0], wb_wdata, wb_sel) &
                       mcp_pkg::MCP_MASK_SYS_GATES;
        end
        mcp_pkg::MCP_IDX_A_GATES: begin
          n.gates[1] = mcp_merge(r.gates[1], wb_wdata, wb_sel) & mcp_pkg::MCP_MASK_A_GATES;
        end
        mcp_pkg::MCP_IDX_B_GATES: begin
          n.gates[2] = mcp_merge(r.gates[2], wb_wdata, wb_sel) & mcp_pkg::MCP_MASK_B_GATES;
        end
        mcp_pkg::MCP_IDX_C_GATES: begin
          n.gates[3] = mcp_merge(r.gates[3], wb_wdata, wb_sel) & mcp_pkg::MCP_MASK_C_GATES;
        end
        mcp_pkg::MCP_IDX_IRQ_ENCLR: begin
          if (wb_sel[0]) begin
            n.irq_en = r.irq_en & ~wb_wdata[1:0];
          end
        end
        mcp_pkg::MCP_IDX_IRQ_ENSET: begin
          if (wb_sel[0]) begin
            n.irq_en = r.irq_en | wb_wdata[1:0];
          end
        end
        mcp_pkg::MCP_IDX_IRQ_FLAGS: begin
          if (wb_sel[0]) begin
            n.irq_flag = r.irq_flag & ~wb_wdata[1:0];
          end
        end
        default: begin
          n.irq_flag = n.irq_flag;
        end
      endcase
    end

    // hardware events after software writes so a set beats a clear
    if (!frozen) begin
      n.fail_seen = clock_failure_detect & r.failure_detector_enable;
      if (fail_event) begin
        n.backup_source_select                = 1'b1;
        n.irq_flag[mcp_pkg::MCP_BIT_CLK_FAIL] = 1'b1;
      end
      if (clock_ready_event) begin
        n.irq_flag[mcp_pkg::MCP_BIT_CLK_READY] = 1'b1;
      end
    end
    n.irq = |(n.irq_flag & n.irq_en);

    // sleep sequencing
    case (r.state)
      mcp_pkg::MCP_ACTIVE: begin
        if (wait_for_interrupt_instruction) begin
          n.state = sleep_deep ? mcp_pkg::MCP_STANDBY : mcp_pkg::MCP_IDLE;
        end
      end
      mcp_pkg::MCP_IDLE: begin
        if (wake_interrupt) begin
          n.state = mcp_pkg::MCP_ACTIVE;
        end
      end
      mcp_pkg::MCP_STANDBY: begin
        if (wake_interrupt) begin
          n.state = mcp_pkg::MCP_ACTIVE;
        end
      end
      default: begin
        n.state = mcp_pkg::MCP_ACTIVE;
      end
    endcase

    // domains stopped by the idle level; reserved code acts like the deepest
    stop_cpu = (r.state != mcp_pkg::MCP_ACTIVE);
    stop_sys = frozen | ((r.state == mcp_pkg::MCP_IDLE) &&
                         (r.idle_cfg != mcp_pkg::MCP_IDLE_CPU));
    stop_bus = frozen | ((r.state == mcp_pkg::MCP_IDLE) &&
                         (r.idle_cfg != mcp_pkg::MCP_IDLE_CPU) &&
                         (r.idle_cfg != mcp_pkg::MCP_IDLE_SYS));

    // power-of-two dividers; a new code is taken only at period end
    for (int d = 0; d < mcp_pkg::MCP_DOMAINS; d++) begin
      n.div_tick[d] = 1'b0;
      // counters hold in standby, so a wake never yields a short period
      if (!frozen) begin
        if (r.div_cnt[d] >= mcp_period_last(r.div_active[d])) begin
          n.div_cnt[d]    = '0;
          n.div_active[d] = r.div_code[d];
          n.div_tick[d]   = 1'b1;
        end else begin
          n.div_cnt[d] = r.div_cnt[d] + 7'h01;
        end
      end
    end
    // system bus runs off the cpu divider but keeps its own stop
    n.sys_tick    = n.div_tick[0] & ~stop_sys;
    n.div_tick[0] = n.div_tick[0] & ~stop_cpu;
    for (int d = 1; d < mcp_pkg::MCP_DOMAINS; d++) begin
      n.div_tick[d] = n.div_tick[d] & ~stop_bus;
    end
  end

  // single state register; async reset loads constants only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      r <= MCP_RESET_STATE;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign wb_rdata                = r.rdata;
  assign wb_ack                  = r.ack;
  assign main_clock_from_backup  = r.backup_source_select;
  assign failure_detector_on     = r.failure_detector_enable;
  assign cpu_clock_enable        = r.div_tick[0];
  assign system_bus_clock_enable = r.sys_tick;
  assign bus_a_clock_enable      = r.div_tick[1];
  assign bus_b_clock_enable      = r.div_tick[2];
  assign bus_c_clock_enable      = r.div_tick[3];
  assign system_bus_gates        = r.gates[0];
  assign bus_a_gates             = r.gates[1];
  assign bus_b_gates             = r.gates[2];
  assign bus_c_gates             = r.gates[3];
  assign irq                     = r.irq;

endmodule : mcp_clock_control

// File: tb/mcp_clock_control_sva.sv
// concurrent checks on the ports of the clock prescaler control block
module mcp_clock_control_sva (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        wb_cyc,
  input wire logic        wb_stb,
  input wire logic        wb_we,
  input wire logic        wb_ack,
  input wire logic        write_protect,
  input wire logic        clock_failure_detect,
  input wire logic        clock_ready_event,
  input wire logic        wait_for_interrupt_instruction,
  input wire logic        sleep_deep,
  input wire logic        wake_interrupt,
  input wire logic        main_clock_from_backup,
  input wire logic        failure_detector_on,
  input wire logic        cpu_clock_enable,
  input wire logic        system_bus_clock_enable,
  input wire logic        bus_a_clock_enable,
  input wire logic        bus_c_clock_enable,
  input wire logic [31:0] system_bus_gates,
  input wire logic [31:0] bus_c_gates,
  input wire logic        irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic fail_prev_r;
  // last enabled detector level, as the block latches it, so a held failure counts once
  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      fail_prev_r <= 1'h0;
    else
      fail_prev_r <= clock_failure_detect && failure_detector_on;
  end
  sequence req_taken; wb_cyc && wb_stb && !wb_ack; endsequence
  sequence wr_commit; wb_ack && wb_we; endsequence
  sequence fail_edge; failure_detector_on && clock_failure_detect && !fail_prev_r; endsequence
  sequence sleep_req; wait_for_interrupt_instruction && !wake_interrupt ##1 !wake_interrupt;
  endsequence
  // the sleep depth counts at the edge that takes the sleep request
  sequence deep_req;
    wait_for_interrupt_instruction && sleep_deep && !wake_interrupt ##1 !wake_interrupt;
  endsequence
  ack_latency_a: assert property (req_taken |=> wb_ack)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_ack |=> !wb_ack)
    else $error("ack longer than one cycle");
  fail_backup_a: assert property (fail_edge |=> main_clock_from_backup)
    else $error("failure did not select backup clock");
  backup_cause_a: assert property ($rose(main_clock_from_backup) |->
    $past(wb_ack && wb_we) || $past(failure_detector_on && clock_failure_detect && !fail_prev_r))
    else $error("backup select rose without cause");
  protect_hold_a: assert property (wr_commit ##0 write_protect |=>
    $stable(failure_detector_on) && $stable(bus_c_gates)) else $error("protected write landed");
  gates_hold_a: assert property (!(wb_ack && wb_we) |=>
    $stable(system_bus_gates) && $stable(bus_c_gates)) else $error("gates moved without write");
  irq_cause_a: assert property ($rose(irq) |->
    $past(clock_ready_event || (wb_ack && wb_we) || clock_failure_detect))
    else $error("irq rose without cause");
  idle_stop_a: assert property (sleep_req |=> !cpu_clock_enable)
    else $error("cpu clock runs in sleep");
  standby_stop_a: assert property (deep_req |=> !bus_a_clock_enable &&
    !bus_c_clock_enable && !system_bus_clock_enable) else $error("clocks run in standby");
  cpu_sys_a: assert property (cpu_clock_enable |-> system_bus_clock_enable)
    else $error("system bus clock lost cpu divider");
endmodule : mcp_clock_control_sva

bind mcp_clock_control mcp_clock_control_sva u_sva (.clock, .reset, .wb_cyc, .wb_stb, .wb_we,
  .wb_ack, .write_protect, .clock_failure_detect, .clock_ready_event,
  .wait_for_interrupt_instruction, .sleep_deep, .wake_interrupt, .main_clock_from_backup,
  .failure_detector_on, .cpu_clock_enable, .system_bus_clock_enable, .bus_a_clock_enable,
  .bus_c_clock_enable, .system_bus_gates, .bus_c_gates, .irq);

// File: tb/testbench.sv
// self-checking bench for the clock prescaler control block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic we; logic [7:0] adr; logic [3:0] sel; logic [31:0] dat, exp;} mcp_row_type;
  logic        clock, reset, wb_cyc, wb_stb, wb_we, wb_ack, write_protect, irq;
  logic        clock_failure_detect, clock_ready_event, wait_for_interrupt_instruction;
  logic        sleep_deep, wake_interrupt, main_clock_from_backup, failure_detector_on;
  logic [4:0]  en;
  logic [3:0]  wb_sel;
  logic [7:0]  wb_adr, reset_cause;
  logic [31:0] wb_wdata, wb_rdata, system_bus_gates, bus_a_gates, bus_b_gates, bus_c_gates;
  logic [2:0]  codes [4] = '{3'h7, 3'h3, 3'h6, 3'h7};
  int          doms [4] = '{0, 2, 3, 4};
  int          num_errors, comparisons, cycles, seen, gap;
  // write then read back where we is set; expected read beside each
  mcp_row_type rows [16] = '{
    '{1'h0, 8'h00, 4'hf, 32'h0, 32'h0}, '{1'h0, 8'h04, 4'hf, 32'h0, 32'h0},
    '{1'h0, 8'h50, 4'hf, 32'h0, 32'h7f}, '{1'h0, 8'h80, 4'hf, 32'h0, 32'h000fffff},
    '{1'h0, 8'he0, 4'hf, 32'h0, 32'h77}, '{1'h1, 8'h50, 4'h1, 32'hff, 32'h1f},
    '{1'h1, 8'h80, 4'hc, 32'h00030000, 32'h0003ffff}, '{1'h1, 8'h60, 4'hf, 32'h0, 32'h0},
    '{1'h1, 8'h0c, 4'hf, 32'hffffffff, 32'h0}, '{1'h1, 8'h20, 4'h1, 32'h7, 32'h7},
    '{1'h1, 8'h24, 4'h1, 32'h3, 32'h3}, '{1'h1, 8'h28, 4'h1, 32'h6, 32'h6},
    '{1'h1, 8'h2c, 4'h1, 32'hff, 32'h7}, '{1'h1, 8'h04, 4'h1, 32'hff, 32'h3},
    '{1'h1, 8'he0, 4'h1, 32'h0, 32'h77}, '{1'h1, 8'h70, 4'h1, 32'hff, 32'h0f}};

  mcp_clock_control u_dut (.clock, .reset, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel,
    .wb_wdata, .wb_rdata, .wb_ack, .write_protect, .clock_failure_detect, .clock_ready_event,
    .wait_for_interrupt_instruction, .sleep_deep, .wake_interrupt, .reset_cause,
    .main_clock_from_backup, .failure_detector_on, .cpu_clock_enable(en[0]),
    .system_bus_clock_enable(en[1]), .bus_a_clock_enable(en[2]), .bus_b_clock_enable(en[3]),
    .bus_c_clock_enable(en[4]), .system_bus_gates, .bus_a_gates, .bus_b_gates, .bus_c_gates,
    .irq);

  task automatic print_verdict();
    $display("counts: %0d comparisons, %0d errors", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= s;
    wb_wdata <= d;
    // no fixed wait is assumed; only the hang guard ends a missing ack
    do begin
      @(posedge clock);
    end while (wb_ack !== 1'h1);
    q = wb_rdata;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    @(posedge clock);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, a, s, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'h0, a, 4'hf, 32'h0, q);
    check(q, e);
  endtask : rd

  task automatic tick(int n);
    repeat (n) @(posedge clock);
  endtask : tick

  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  // hang guard; the whole run needs well under two thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("ERROR at %0t: timeout, cycles %h limit %h", $time, cycles, 32'h00004e20);
      print_verdict();
    end
  end

  initial begin
    {wb_cyc, wb_stb, wb_we, write_protect, clock_failure_detect} = 5'h0;
    {clock_ready_event, wait_for_interrupt_instruction, sleep_deep, wake_interrupt} = 4'h0;
    {wb_adr, wb_sel, wb_wdata} = 44'h0;
    reset_cause = 8'hff;
    reset = 1'h1;
    tick(2);
    reset <= 1'h0;
    tick(1);
    foreach (rows[i]) begin
      if (rows[i].we)
        wr(rows[i].adr, rows[i].sel, rows[i].dat);
      rd(rows[i].adr, rows[i].exp);
    end
    check(system_bus_gates, 32'h0000001f);
    check(bus_a_gates, 32'h00000000);
    check(bus_b_gates, 32'h0000000f);
    check(bus_c_gates, 32'h0003ffff);
    $display("register table done");
    // old period may finish first, so the gap between the 2nd and 3rd pulse is measured
    foreach (codes[i]) begin
      seen = 0;
      gap = 0;
      while (seen < 3 && gap < 600) begin
        tick(1);
        gap++;
        if (en[doms[i]] === 1'h1) begin
          seen++;
          if (seen < 3)
            gap = 0;
        end
      end
      check(32'(gap), 32'h1 << codes[i]);
    end
    $display("divider periods done");
    wr(8'hd4, 4'h1, 32'h1);
    clock_ready_event <= 1'h1;
    tick(1);
    clock_ready_event <= 1'h0;
    tick(1);
    check(32'(irq), 32'h1);
    rd(8'hd8, 32'h1);
    wr(8'hd0, 4'h1, 32'h1);
    check(32'(irq), 32'h0);
    rd(8'hd4, 32'h0);
    wr(8'hd4, 4'h1, 32'h1);
    check(32'(irq), 32'h1);
    wr(8'hd8, 4'h1, 32'h1);
    check(32'(irq), 32'h0);
    $display("interrupt test done");
    wr(8'h00, 4'h1, 32'h4);
    check(32'(failure_detector_on), 32'h1);
    wr(8'hd4, 4'h1, 32'h2);
    clock_failure_detect <= 1'h1;
    tick(1);
    clock_failure_detect <= 1'h0;
    tick(1);
    check(32'(main_clock_from_backup), 32'h1);
    check(32'(irq), 32'h1);
    rd(8'h00, 32'h14);
    rd(8'hd8, 32'h2);
    wr(8'hd8, 4'h1, 32'h2);
    write_protect <= 1'h1;
    wr(8'h00, 4'h1, 32'h0);
    wr(8'h70, 4'h1, 32'h0);
    rd(8'h00, 32'h14);
    rd(8'h70, 32'h0f);
    write_protect <= 1'h0;
    wr(8'h00, 4'h1, 32'h0);
    check(32'({main_clock_from_backup, failure_detector_on}), 32'h0);
    $display("failure and protection done");
    for (int i = 0; i < 4; i++)
      wr(8'h20 + 8'(4 * i), 4'h1, 32'h0);
    // old periods of up to 128 cycles must finish before code 0 takes hold
    tick(130);
    // codes 0..3 idle, reserved 3 acting like 2; pass 4 is standby over code 0
    for (int k = 0; k < 5; k++) begin
      wr(8'h04, 4'h1, 32'(k));
      sleep_deep <= (k == 4);
      wait_for_interrupt_instruction <= 1'h1;
      tick(1);
      wait_for_interrupt_instruction <= 1'h0;
      tick(3);
      check(32'(en), 32'({{3{k < 2}}, k < 1, 1'h0}));
      rd(8'h04, 32'(k % 4));
      wake_interrupt <= 1'h1;
      tick(1);
      wake_interrupt <= 1'h0;
      tick(2);
      check(32'(en), 32'h1f);
    end
    sleep_deep <= 1'h0;
    $display("sleep levels done");
    reset <= 1'h1;
    tick(1);
    reset <= 1'h0;
    tick(1);
    rd(8'h04, 32'h0);
    rd(8'h2c, 32'h0);
    $display("second reset done");
    print_verdict();
  end
endmodule : testbench
